/* File: core/burst_regs.vh */
`ifndef BURST_REGS_VH
`define BURST_REGS_VH

// Operating modes.
`define BM_MODE_OFF 3'h0
`define BM_MODE_INT 3'h1
`define BM_MODE_EXT 3'h2
`define BM_MODE_BUS 3'h3
`define BM_MODE_GATE 3'h4

// Trigger origin codes.
`define BM_TRIG_IMM 2'h0
`define BM_TRIG_EXT 2'h1
`define BM_TRIG_BUS 2'h2

// Burst states.
`define BM_ST_IDLE 1'h0
`define BM_ST_RUN 1'h1

// Cycle total: 1 to 50000, default 1.
`define BM_CYC_MIN 16'h0001
`define BM_CYC_MAX 16'hc350
`define BM_CYC_RST 16'h0001

// Burst rate in mHz: 10 mHz to 50 kHz, default 100 Hz.
`define BM_RATE_MIN 26'h000000a
`define BM_RATE_MAX 26'h2faf080
`define BM_RATE_RST 26'h00186a0

// Start angle in millidegrees: -360000 to +360000, default 0.
`define BM_ANG_MAX 20'h57e40
`define BM_ANG_MIN 20'ha81c0
`define BM_ANG_RST 20'h00000

// Carrier in mHz: 10 mHz to 5 MHz (100 kHz triangle/ramp), default 1 kHz.
`define BM_FREQ_MIN 34'h00000000a
`define BM_FREQ_MAX 34'h12a05f200
`define BM_FREQ_MAX_TR 34'h005f5e100
`define BM_FREQ_RST 34'h0000f4240
`define BM_FREQ_PER_CYC 34'h03b9aca00
`define BM_CYC_FULL_SPEED 16'h0005

// Longest burst duration at low carrier frequencies, in seconds.
`define BM_MAX_BURST_S 500
// One cycle per 500 s is 2 mHz; sized so the product keeps its full width.
`define BM_MHZ_PER_CYC 34'h000000002

// Clock rate and the rate accumulator wrap (clock in mHz).
`define BM_CLK_HZ 100000000
`define BM_RATE_WRAP 37'h174876e800

// Settings conflict error code (-221, 10-bit two's complement).
`define BM_ERR_NONE 10'h000
`define BM_ERR_CONFLICT 10'h323

`endif

/* File: core/level_sync.v */
`timescale 1ns/1ns

module level_sync (
	input wire i_clk,
	input wire i_reset,
	input wire i_async,
	output reg o_sync
);

reg meta_reg;

always @(posedge i_clk) begin
	if (i_reset) begin
		meta_reg <= 1'b0;
		o_sync <= 1'b0;
	end else begin
		meta_reg <= i_async;
		o_sync <= meta_reg;
	end
end

endmodule // level_sync

/* File: core/carrier_freq_limiter.v */
`timescale 1ns/1ns
`include "burst_regs.vh"

module carrier_freq_limiter (
	input wire [33:0] i_req,
	input wire [15:0] i_count,
	input wire i_tri_ramp,
	input wire i_burst_on,
	output reg [33:0] o_freq,
	output reg o_conflict
);

reg [33:0] hi;
reg [33:0] lo;
reg [33:0] low_bound;

always @* begin
	hi = `BM_FREQ_MAX;
	lo = `BM_FREQ_MIN;
	low_bound = {18'h00000, i_count} * `BM_MHZ_PER_CYC;
	if (i_tri_ramp) begin
		hi = `BM_FREQ_MAX_TR;
	end else if (i_count < `BM_CYC_FULL_SPEED) begin
		hi = {31'h00000000, i_count[2:0]} * `BM_FREQ_PER_CYC;
	end
	if (low_bound > lo) begin
		lo = low_bound;
	end
	o_freq = i_req;
	o_conflict = 1'b0;
	if (i_burst_on && i_req > hi) begin
		o_freq = hi;
		o_conflict = 1'b1;
	end else if (i_burst_on && i_req < lo) begin
		o_freq = lo;
		o_conflict = 1'b1;
	end
end

endmodule // carrier_freq_limiter

/* File: core/burst_modulation_control.v */
`timescale 1ns/1ns
`include "burst_regs.vh"

// Notes on behaviour
// - Each trigger emits exactly the cycle total.
// - One mode, from trigger and burst origin.
// - Reset starts internally triggered mode.
// - Triggers: rate generator, single key, pin.
// - Gated: carrier while pin high, else off.
// - Gated mode ignores count, rate, angle, trigger; the carrier clamp still uses the count.
// - Internal origin disables gating; default internal.
// - Rate used only with internal trigger.
// - Cycle total 1 to 50000, default 1.
// - Minimum cycle total rises per MHz band.
// - Too high carrier clamps down, remote error.
// - Count over frequency at most 500 s.
// - Start angle +-360 degrees, millidegree steps.
// - Zero angle is the rising zero crossing.
// - Rate 10 mHz to 50 kHz, default 100 Hz.
// - Too fast rate retriggers back to back.
// - Carrier 10 mHz to 5 MHz in burst.
// - External trigger starts on rising edge.
// - Output idles at offset between bursts.
// - Bus trigger command emits one burst.
module burst_modulation_control (
	input wire i_clk,
	input wire i_reset,
	input wire i_ext_trig,
	input wire i_single_key,
	input wire i_bus_trigger,
	input wire i_carrier_cycle_end,
	input wire i_burst_enable_switch,
	input wire i_set_source,
	input wire [1:0] i_trigger_origin_select,
	input wire i_burst_origin_select,
	input wire i_set_count,
	input wire [15:0] i_burst_cycle_total,
	input wire i_set_rate,
	input wire [25:0] i_internal_burst_interval_rate,
	input wire i_set_angle,
	input wire [19:0] i_burst_start_angle,
	input wire i_set_freq,
	input wire [33:0] i_carrier_freq_req,
	input wire i_freq_remote,
	input wire i_shape_tri_ramp,
	output reg o_carrier_gate,
	output reg o_phase_load,
	output reg o_burst_active,
	output reg o_trig_wait,
	output reg [2:0] o_mode,
	output reg [1:0] o_trigger_origin_select,
	output reg o_burst_origin_select,
	output reg [15:0] o_burst_cycle_total,
	output reg [25:0] o_internal_burst_interval_rate,
	output reg [19:0] o_burst_start_angle,
	output reg [33:0] o_carrier_freq,
	output reg o_conflict_error,
	output reg [9:0] o_error_code
);

////////////////////////////////////////////////////////////////////////////////

wire ext_level;
wire [33:0] lim_freq;
wire lim_conflict;

reg ext_prev_reg;
reg state_reg;
reg [15:0] cyc_cnt_reg;
reg int_pend_reg;
reg [36:0] acc_reg;

reg [2:0] mode_next;
reg [15:0] count_next;
reg [25:0] rate_next;
reg [19:0] angle_next;

wire [36:0] acc_sum;
wire rate_fire;
wire ext_rise;
wire last_cycle;
wire mode_change;
reg trig_now;

// The trigger pin is asynchronous to the sample clock.
level_sync u_ext_sync (
	.i_clk(i_clk),
	.i_reset(i_reset),
	.i_async(i_ext_trig),
	.o_sync(ext_level)
);

// Clamping uses the stored cycle total, so the count must be set first.
carrier_freq_limiter u_limiter (
	.i_req(i_carrier_freq_req),
	.i_count(o_burst_cycle_total),
	.i_tri_ramp(i_shape_tri_ramp),
	.i_burst_on(i_burst_enable_switch),
	.o_freq(lim_freq),
	.o_conflict(lim_conflict)
);

////////////////////////////////////////////////////////////////////////////////

always @* begin
	count_next = i_burst_cycle_total;
	if (i_burst_cycle_total < `BM_CYC_MIN) begin
		count_next = `BM_CYC_MIN;
	end else if (i_burst_cycle_total > `BM_CYC_MAX) begin
		count_next = `BM_CYC_MAX;
	end
	rate_next = i_internal_burst_interval_rate;
	if (i_internal_burst_interval_rate < `BM_RATE_MIN) begin
		rate_next = `BM_RATE_MIN;
	end else if (i_internal_burst_interval_rate > `BM_RATE_MAX) begin
		rate_next = `BM_RATE_MAX;
	end
	angle_next = i_burst_start_angle;
	if ($signed(i_burst_start_angle) > $signed(`BM_ANG_MAX)) begin
		angle_next = `BM_ANG_MAX;
	end else if ($signed(i_burst_start_angle) < $signed(`BM_ANG_MIN)) begin
		angle_next = `BM_ANG_MIN;
	end
end

// Settings registers, with their readback on the outputs.
always @(posedge i_clk) begin
	if (i_reset) begin
		o_trigger_origin_select <= `BM_TRIG_IMM;
		o_burst_origin_select <= 1'b0;
		o_burst_cycle_total <= `BM_CYC_RST;
		o_internal_burst_interval_rate <= `BM_RATE_RST;
		o_burst_start_angle <= `BM_ANG_RST;
		o_carrier_freq <= `BM_FREQ_RST;
		o_conflict_error <= 1'b0;
		o_error_code <= `BM_ERR_NONE;
	end else begin
		if (i_set_source) begin
			o_trigger_origin_select <= i_trigger_origin_select;
			o_burst_origin_select <= i_burst_origin_select;
		end
		if (i_set_count) begin
			o_burst_cycle_total <= count_next;
		end
		if (i_set_rate) begin
			o_internal_burst_interval_rate <= rate_next;
		end
		if (i_set_angle) begin
			o_burst_start_angle <= angle_next;
		end
		if (i_set_freq) begin
			o_carrier_freq <= lim_freq;
		end
		o_conflict_error <= i_set_freq & lim_conflict & i_freq_remote;
		if (i_set_freq && lim_conflict && i_freq_remote) begin
			o_error_code <= `BM_ERR_CONFLICT;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////

always @* begin
	mode_next = `BM_MODE_OFF;
	if (i_burst_enable_switch) begin
		if (o_burst_origin_select) begin
			mode_next = `BM_MODE_GATE;
		end else begin
			case (o_trigger_origin_select)
				`BM_TRIG_IMM: begin
					mode_next = `BM_MODE_INT;
				end
				`BM_TRIG_EXT: begin
					mode_next = `BM_MODE_EXT;
				end
				`BM_TRIG_BUS: begin
					mode_next = `BM_MODE_BUS;
				end
				default: begin
					mode_next = `BM_MODE_INT;
				end
			endcase
		end
	end
end

assign mode_change = (mode_next != o_mode);

always @(posedge i_clk) begin
	if (i_reset) begin
		o_mode <= `BM_MODE_OFF;
	end else begin
		o_mode <= mode_next;
	end
end

////////////////////////////////////////////////////////////////////////////////

// The accumulator adds the rate in mHz each clock and wraps at the clock
// rate in mHz, so the average spacing is exact without any divider.
assign acc_sum = acc_reg + {11'h000, o_internal_burst_interval_rate};

assign rate_fire = (o_mode == `BM_MODE_INT) && (acc_sum >= `BM_RATE_WRAP);

always @(posedge i_clk) begin
	if (i_reset || o_mode != `BM_MODE_INT) begin
		acc_reg <= 37'h0000000000;
	end else if (rate_fire) begin
		acc_reg <= acc_sum - `BM_RATE_WRAP;
	end else begin
		acc_reg <= acc_sum;
	end
end

assign ext_rise = ext_level & ~ext_prev_reg;

always @(posedge i_clk) begin
	if (i_reset) begin
		ext_prev_reg <= 1'b0;
	end else begin
		ext_prev_reg <= ext_level;
	end
end

always @* begin
	case (o_mode)
		`BM_MODE_INT: begin
			trig_now = rate_fire | int_pend_reg | i_single_key;
		end
		`BM_MODE_EXT: begin
			trig_now = ext_rise | i_single_key;
		end
		`BM_MODE_BUS: begin
			trig_now = i_bus_trigger | i_single_key;
		end
		default: begin
			trig_now = 1'b0;
		end
	endcase
end

assign last_cycle = i_carrier_cycle_end && (cyc_cnt_reg + 16'h0001 >= o_burst_cycle_total);

// A rate tick that lands inside a burst is held, so a rate faster than the
// burst length turns into continuous retriggering instead of lost bursts.
always @(posedge i_clk) begin
	if (i_reset || o_mode != `BM_MODE_INT) begin
		int_pend_reg <= 1'b0;
	end else if (state_reg == `BM_ST_IDLE || last_cycle) begin
		int_pend_reg <= 1'b0;
	end else if (rate_fire) begin
		// keep tick for back to back
		int_pend_reg <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////

// The synthesizer restarts from the start angle on o_phase_load; it owns the
// angle reference, with zero at the rising crossing or the first stored point.
always @(posedge i_clk) begin
	if (i_reset) begin
		state_reg <= `BM_ST_IDLE;
		cyc_cnt_reg <= 16'h0000;
		o_carrier_gate <= 1'b1;
		o_phase_load <= 1'b0;
		o_burst_active <= 1'b0;
		o_trig_wait <= 1'b0;
	end else begin
		o_phase_load <= 1'b0;
		o_trig_wait <= (o_mode == `BM_MODE_EXT) && (state_reg == `BM_ST_IDLE);
		if (mode_change) begin
			// A mode switch abandons any burst in flight.
			state_reg <= `BM_ST_IDLE;
			cyc_cnt_reg <= 16'h0000;
			o_burst_active <= 1'b0;
			o_carrier_gate <= (mode_next == `BM_MODE_OFF);
		end else if (o_mode == `BM_MODE_OFF) begin
			o_carrier_gate <= 1'b1;
		end else if (o_mode == `BM_MODE_GATE) begin
			o_carrier_gate <= ext_level;
		end else begin
			case (state_reg)
				`BM_ST_IDLE: begin
					if (trig_now) begin
						state_reg <= `BM_ST_RUN;
						cyc_cnt_reg <= 16'h0000;
						o_phase_load <= 1'b1;
						o_carrier_gate <= 1'b1;
						o_burst_active <= 1'b1;
					end else begin
						o_carrier_gate <= 1'b0;
					end
				end
				`BM_ST_RUN: begin
					if (last_cycle) begin
						if (int_pend_reg || rate_fire) begin
							cyc_cnt_reg <= 16'h0000;
							o_phase_load <= 1'b1;
						end else begin
							state_reg <= `BM_ST_IDLE;
							o_carrier_gate <= 1'b0;
							o_burst_active <= 1'b0;
						end
					end else if (i_carrier_cycle_end) begin
						cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
					end
				end
				default: begin
					state_reg <= `BM_ST_IDLE;
					o_carrier_gate <= 1'b0;
					o_burst_active <= 1'b0;
				end
			endcase
		end
	end
end

endmodule // burst_modulation_control

/* File: verif/burst_checker_props.sv */
`timescale 1ns/1ns
module burst_checker (
	input wire i_clk,
	input wire i_reset,
	input wire i_ext_trig,
	input wire i_bus_trigger,
	input wire i_carrier_cycle_end,
	input wire i_set_count,
	input wire [15:0] i_burst_cycle_total,
	input wire o_carrier_gate,
	input wire o_phase_load,
	input wire o_burst_active,
	input wire [2:0] o_mode,
	input wire [15:0] o_burst_cycle_total,
	input wire [19:0] o_burst_start_angle,
	input wire o_conflict_error,
	input wire [9:0] o_error_code
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_reset);
// Ends seen in the running burst; a restart reloads it with the end of that very cycle.
reg [15:0] ends_reg;
always @(posedge i_clk) begin
	if (i_reset)
		ends_reg <= 16'h0000;
	else if (o_phase_load)
		ends_reg <= {15'h0000, i_carrier_cycle_end};
	else if (o_burst_active && i_carrier_cycle_end)
		ends_reg <= ends_reg + 16'h0001;
end
sequence s_bus_fire;
	o_mode == 3'h3 && !o_burst_active && i_bus_trigger;
endsequence
sequence s_burst_open;
	o_phase_load && o_carrier_gate && o_burst_active;
endsequence
sequence s_last_end;
	o_mode == 3'h3 && o_burst_active && i_carrier_cycle_end && ends_reg + 16'h0001 == o_burst_cycle_total;
endsequence
a_reset_defaults: assert property ($fell(i_reset) |->
	o_burst_cycle_total == 16'h0001 && o_burst_start_angle == 20'h00000) else $error("defaults");
a_count_range: assert property (
	o_burst_cycle_total >= 16'h0001 && o_burst_cycle_total <= 16'hc350) else $error("count range");
a_count_load: assert property (i_set_count && i_burst_cycle_total != 16'h0000 &&
	i_burst_cycle_total <= 16'hc350 |=> o_burst_cycle_total == $past(i_burst_cycle_total))
	else $error("count load");
a_conflict_code: assert property (o_conflict_error |-> o_error_code == 10'h323)
	else $error("conflict code");
a_phase_gate: assert property (o_phase_load |-> o_carrier_gate) else $error("phase gate");
a_bus_start: assert property (s_bus_fire |=> s_burst_open) else $error("bus start");
a_burst_end: assert property (s_last_end |=> !o_burst_active && !o_carrier_gate)
	else $error("burst end");
a_no_retrig: assert property (o_mode == 3'h3 && o_burst_active && $past(o_burst_active)
	|-> !o_phase_load) else $error("retrigger");
a_idle_offset: assert property (o_mode == 3'h3 && $past(o_mode) == 3'h3 && !o_burst_active
	&& !$past(o_burst_active) |-> !o_carrier_gate) else $error("idle level");
a_gate_follow: assert property ((o_mode == 3'h4 && $stable(i_ext_trig))[*8]
	|-> o_carrier_gate == i_ext_trig) else $error("gate follow");
endmodule // burst_checker
bind burst_modulation_control burst_checker chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_ext_trig(i_ext_trig), .i_bus_trigger(i_bus_trigger),
	.i_carrier_cycle_end(i_carrier_cycle_end), .i_set_count(i_set_count),
	.i_burst_cycle_total(i_burst_cycle_total), .o_carrier_gate(o_carrier_gate),
	.o_phase_load(o_phase_load), .o_burst_active(o_burst_active), .o_mode(o_mode),
	.o_burst_cycle_total(o_burst_cycle_total), .o_burst_start_angle(o_burst_start_angle),
	.o_conflict_error(o_conflict_error), .o_error_code(o_error_code));

/* File: verif/ext_source_model.sv */
`timescale 1ns/1ns
module ext_source_model (
	input wire i_clk,
	input wire i_pulse,
	input wire i_level,
	output reg o_pin
);
reg [1:0] hold_reg = 2'h0;
initial o_pin = 1'b0;
always @(posedge i_clk) begin
	hold_reg <= i_pulse ? 2'h2 : (hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0);
	o_pin <= i_level || i_pulse || hold_reg > 2'h1;
end
endmodule // ext_source_model

/* File: verif/testbench.sv */
`timescale 1ns/1ns
module testbench;
reg i_clk = 1'b0;
reg i_reset = 1'b1;
reg key = 0, bus = 0, en = 1, s_src = 0, b_src = 0, s_cnt = 0, s_rate = 0, s_ang = 0;
reg s_frq = 0, remote = 0, tri_r = 0, pulse = 0, level = 0, ce = 0, was = 0;
reg [1:0] t_src = 2'h0;
reg [1:0] div = 2'h0;
reg [2:0] sel = 3'h0;
reg [15:0] cnt = 16'h0001;
reg [25:0] rate = 26'h000000a;
reg [19:0] ang = 20'h00000;
reg [33:0] frq = 34'h000000000;
reg [33:0] exp_q[$];
reg [33:0] burst_q[$];
integer miscompares = 0, n_compared = 0, ends = 0, loads = 0, errs = 0, k;
integer seed = 32'hd4293d46;
event chk_ev;
wire ext, gate, pl, act, tw, bsel, cerr;
wire [1:0] tsel;
wire [2:0] mode;
wire [15:0] ncyc;
wire [25:0] brate;
wire [19:0] bang;
wire [33:0] cfreq;
wire [9:0] ecode;
wire [33:0] obs = sel == 3'h0 ? ncyc : sel == 3'h1 ? brate : sel == 3'h2 ? bang :
	sel == 3'h3 ? cfreq : sel == 3'h4 ? ecode : sel == 3'h5 ? mode : sel == 3'h6 ? gate :
	{tw, tsel, bsel};
ext_source_model src (.i_clk(i_clk), .i_pulse(pulse), .i_level(level), .o_pin(ext));
burst_modulation_control uut (.i_clk(i_clk), .i_reset(i_reset), .i_ext_trig(ext),
	.i_single_key(key), .i_bus_trigger(bus), .i_carrier_cycle_end(ce),
	.i_burst_enable_switch(en), .i_set_source(s_src), .i_trigger_origin_select(t_src),
	.i_burst_origin_select(b_src), .i_set_count(s_cnt), .i_burst_cycle_total(cnt),
	.i_set_rate(s_rate), .i_internal_burst_interval_rate(rate), .i_set_angle(s_ang),
	.i_burst_start_angle(ang), .i_set_freq(s_frq), .i_carrier_freq_req(frq),
	.i_freq_remote(remote), .i_shape_tri_ramp(tri_r), .o_carrier_gate(gate),
	.o_phase_load(pl), .o_burst_active(act), .o_trig_wait(tw), .o_mode(mode),
	.o_trigger_origin_select(tsel), .o_burst_origin_select(bsel), .o_burst_cycle_total(ncyc),
	.o_internal_burst_interval_rate(brate), .o_burst_start_angle(bang),
	.o_carrier_freq(cfreq), .o_conflict_error(cerr), .o_error_code(ecode));
////////////////////////////////////////////////////////////////////////////////
initial forever #5 i_clk = ~i_clk;
// Synthesizer stand-in: a carrier cycle ends every fourth clock, counted from each restart.
always @(posedge i_clk) begin
	div <= pl ? 2'h0 : div + 2'h1;
	ce <= !pl && div == 2'h2;
end
task compare(input [33:0] seen, input [33:0] want);
	begin
		n_compared = n_compared + 1;
		if (seen !== want) begin
			miscompares = miscompares + 1;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	end
endtask
task expect_val(input [2:0] s, input [33:0] v);
	begin
		sel = s;
		exp_q.push_back(v);
		#1 -> chk_ev;
		#1;
	end
endtask
task put(input [2:0] s, input [33:0] v);
	begin
		@(posedge i_clk);
		case (s)
			3'h0: begin s_cnt <= 1; cnt <= v[15:0]; end
			3'h1: begin s_rate <= 1; rate <= v[25:0]; end
			3'h2: begin s_ang <= 1; ang <= v[19:0]; end
			3'h3: begin s_frq <= 1; frq <= v; end
			default: begin s_src <= 1; t_src <= v[1:0]; b_src <= v[2]; end
		endcase
		@(posedge i_clk);
		{s_cnt, s_rate, s_ang, s_frq, s_src} <= 5'h00;
		@(posedge i_clk);
		#1;
	end
endtask
task chk_set(input [2:0] s, input [33:0] v, input [33:0] want);
	begin
		put(s, v);
		expect_val(s, want);
	end
endtask
task wait_idle;
	begin
		repeat (300) if (act === 1'b1) @(posedge i_clk);
		repeat (3) @(posedge i_clk);
	end
endtask
task report_and_stop;
	begin
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
endtask
////////////////////////////////////////////////////////////////////////////////
initial forever begin
	@(chk_ev);
	compare(obs, exp_q.pop_front());
end
// Gated mode has no counted bursts, so its edges are not judged here.
always @(posedge i_clk) begin
	was <= act;
	if (act && ce) ends = ends + 1;
	if (pl) loads = loads + 1;
	if (cerr) errs = errs + 1;
	if (was && !act && mode != 3'h4) begin
		compare(ends, burst_q.pop_front());
		compare(loads, 1);
	end
	if (!act) begin ends = 0; loads = 0; end
end
initial begin
	#100000;
	miscompares = miscompares + 1;
	report_and_stop;
end
initial begin
	repeat (5) @(posedge i_clk);
	i_reset <= 1'b0;
	@(posedge i_clk);
	#1;
	expect_val(0, 1);
	expect_val(1, 34'h00186a0);
	expect_val(2, 0);
	expect_val(3, 34'h0000f4240);
	chk_set(0, 0, 1);
	chk_set(0, 60000, 50000);
	k = {$random(seed)} % 50000 + 1;
	chk_set(0, k, k);
	chk_set(1, 5, 10);
	chk_set(2, 34'h80000, 34'ha81c0);
	chk_set(2, 34'h12345, 34'h12345);
	expect_val(5, 1);
	put(0, 2);
	@(posedge i_clk) remote <= 1'b1;
	chk_set(3, 34'h0b2d05e00, 34'h077359400);
	expect_val(4, 34'h323);
	compare(errs, 1);
	@(posedge i_clk) tri_r <= 1'b1;
	chk_set(3, 34'h00bebc200, 34'h005f5e100);
	put(0, 5000);
	chk_set(3, 34'h5, 34'h2710);
	compare(errs, 3);
	put(0, 1);
	burst_q.push_back(1);
	chk_set(1, 34'h3ffffff, 34'h2faf080);
	repeat (2100) if (act !== 1'b1) @(posedge i_clk);
	wait_idle;
	put(0, 3);
	// Bus, pin and key triggers, each fired twice so the second lands mid-burst.
	for (k = 0; k < 3; k = k + 1) begin
		put(4, k == 0 ? 2 : 1);
		burst_q.push_back(3);
		repeat (2) begin
			@(posedge i_clk);
			bus <= k == 0;
			pulse <= k == 1;
			key <= k == 2;
			@(posedge i_clk);
			{bus, pulse, key} <= 3'h0;
			repeat (4) @(posedge i_clk);
		end
		wait_idle;
		if (k == 2) expect_val(7, 34'ha);
	end
	@(posedge i_clk) en <= 1'b0;
	put(4, 4);
	expect_val(5, 0);
	expect_val(7, 34'h1);
	@(posedge i_clk) en <= 1'b1;
	@(posedge i_clk) level <= 1'b1;
	repeat (10) @(posedge i_clk);
	expect_val(6, 1);
	expect_val(5, 4);
	@(posedge i_clk) level <= 1'b0;
	repeat (10) @(posedge i_clk);
	expect_val(6, 0);
	put(4, 3);
	expect_val(5, 1);
	compare(burst_q.size(), 0);
	report_and_stop;
end
endmodule // testbench
